/* File: src/pto_pkg.sv */
// constants for the trigger output global control block
//
// Contract
// - done flag sets on notified event, W1C
// - interrupt only when unit enable bit set
// - twelve units, bit 0 is unit 1
// - arm bit arms unit, self-clears after fire
// - soft reset idles unit, then self-clears
// - unit 1 delay, 1 ns or 4 ns steps
// - unit 12 width is upper byte plus low word
// - error on past target with notify, cleared by disarm
// - active while armed and error free
// - trigger-now fires at once on past target
package pto_pkg;
   localparam int          UNITS           = 12;
   localparam logic [9:0]  ADDR_ERROR      = 10'h200;
   localparam logic [9:0]  ADDR_ACTIVE     = 10'h202;
   localparam logic [9:0]  ADDR_DONE       = 10'h204;
   localparam logic [9:0]  ADDR_ARM        = 10'h206;
   localparam logic [9:0]  ADDR_SOFT_RST   = 10'h208;
   localparam logic [9:0]  ADDR_WIDTH_COMP = 10'h20A;
   localparam logic [11:0] RST_UNITS       = 12'h000;
   localparam logic [7:0]  RST_WIDTH_UPPER = 8'h00;
   localparam logic [2:0]  RST_DELAY_SEL   = 3'h0;
   localparam logic        RST_FINE_STEP   = 1'b0;
   localparam logic [2:0]  RST_DELAY_CNT   = 3'h0;
   localparam logic [23:0] RST_PPS_WIDTH   = 24'h000000;
   localparam logic [15:0] RST_RDATA       = 16'h0000;
   localparam int          WIDTH_UPPER_LSB = 0;
   localparam int          DELAY_SEL_LSB   = 8;
   localparam int          FINE_STEP_BIT   = 11;
   localparam int          CLK_PERIOD_NS   = 5;
   localparam int          STEP_FINE_NS    = 1;
   localparam int          STEP_COARSE_NS  = 4;
   localparam int          MAX_DELAY_NS    = 28;
   localparam int          MAX_DELAY_CYC   = MAX_DELAY_NS / CLK_PERIOD_NS;
endpackage

/* File: src/pto_trigger_ctrl.sv */
// global control and status for the twelve trigger output units
`timescale 1ns/1ps
module pto_trigger_ctrl
   import pto_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic [9:0]        regAddr,
   input  wire logic              regWrite,
   input  wire logic              regRead,
   input  wire logic [15:0]       regWdata,
   output logic      [15:0]       regRdata,
   output logic                   regRdValid,
   input  wire logic [UNITS-1:0]  trigger_interrupt_enable,
   input  wire logic [UNITS-1:0]  notify_option,
   input  wire logic [UNITS-1:0]  triggerNow,
   input  wire logic [UNITS-1:0]  cascadeMode,
   input  wire logic [4*UNITS-1:0] upstreamSel,
   input  wire logic [UNITS-1:0]  targetReached,
   input  wire logic [UNITS-1:0]  targetPast,
   input  wire logic [15:0]       last_unit_config_second,
   output logic      [UNITS-1:0]  unitFire,
   output logic                   unit1FireDelayed,
   output logic      [UNITS-1:0]  unitSoftReset,
   output logic      [UNITS-1:0]  unit_active_flags,
   output logic      [23:0]       lastUnitPulseWidth,
   output logic                   trigIrq
);

   typedef struct packed {
      logic [UNITS-1:0] unit_arm_bits;
      logic [UNITS-1:0] event_done_flags;
      logic [UNITS-1:0] unit_error_flags;
      logic [UNITS-1:0] unit_soft_reset_bits;
      logic [UNITS-1:0] active;
      logic [UNITS-1:0] fire;
      logic [7:0]       last_unit_pulse_width_upper;
      logic [2:0]       delaySel;
      logic             fineStep;
      logic [2:0]       delayCnt;
      logic             delayPend;
      logic             fireDelayed;
      logic [23:0]      ppsWidth;
      logic             irq;
      logic [15:0]      rdata;
      logic             rdValid;
   } pto_state_t;

   pto_state_t cur;
   pto_state_t next_cur;

   // delay in ns converted to whole clock cycles
   function automatic logic [2:0] delayCycles(input logic [2:0] sel,
                                              input logic       fine);
      int ns;
      ns = fine ? int'(sel) * STEP_FINE_NS : int'(sel) * STEP_COARSE_NS;
      return 3'(ns / CLK_PERIOD_NS);
   endfunction

   function automatic logic [15:0] pad12(input logic [UNITS-1:0] v);
      return {4'h0, v};
   endfunction

   // set beats clear; keep masks the result
   function automatic logic [UNITS-1:0] flagUpdate(
      input logic [UNITS-1:0] flags,
      input logic [UNITS-1:0] setBits,
      input logic [UNITS-1:0] clrBits,
      input logic [UNITS-1:0] keepBits);
      return ((flags & ~clrBits) | setBits) & keepBits;
   endfunction

   logic [UNITS-1:0] wrDone;
   logic [UNITS-1:0] wrArm;
   logic [UNITS-1:0] wrRst;
   logic [UNITS-1:0] errCond;
   logic [UNITS-1:0] fireNow;
   logic [UNITS-1:0] chainArm;
   logic [UNITS-1:0] arm;
   logic [2:0]       cyc;

   always_comb begin
      next_cur = cur;
      wrDone   = '0;
      wrArm    = '0;
      wrRst    = '0;
      chainArm = '0;
      cyc      = delayCycles(cur.delaySel, cur.fineStep);
      if (regWrite) begin
         unique case (regAddr)
            ADDR_DONE:     wrDone = regWdata[UNITS-1:0];
            ADDR_ARM:      wrArm  = '1;
            ADDR_SOFT_RST: wrRst  = regWdata[UNITS-1:0];
            ADDR_WIDTH_COMP: begin
               next_cur.last_unit_pulse_width_upper =
                  regWdata[WIDTH_UPPER_LSB +: 8];
               next_cur.delaySel = regWdata[DELAY_SEL_LSB +: 3];
               next_cur.fineStep = regWdata[FINE_STEP_BIT];
            end
            default: ;
         endcase
      end
      arm = cur.unit_arm_bits;
      for (int i = 0; i < UNITS; i++) begin
         if (wrArm[i]) begin
            arm[i] = regWdata[i];
         end
      end
      errCond = arm & notify_option & targetPast & ~triggerNow;
      fireNow = arm & ~errCond & ~cur.unit_error_flags
                & ~cur.unit_soft_reset_bits
                & (targetReached | (triggerNow & targetPast));
      for (int k = 0; k < UNITS; k++) begin
         for (int j = 0; j < UNITS; j++) begin
            if (cascadeMode[k] && upstreamSel[4*k +: 4] == 4'(j)
                && fireNow[j]) begin
               chainArm[k] = 1'b1;
            end
         end
      end
      arm = (arm & ~fireNow) | chainArm;
      arm = arm & ~cur.unit_soft_reset_bits;
      next_cur.unit_arm_bits = arm;
      next_cur.unit_soft_reset_bits = wrRst;
      next_cur.unit_error_flags = flagUpdate(cur.unit_error_flags, errCond,
                                             '0, arm);
      next_cur.event_done_flags = flagUpdate(cur.event_done_flags,
                                             fireNow & notify_option,
                                             wrDone,
                                             ~cur.unit_soft_reset_bits);
      next_cur.active = arm & ~next_cur.unit_error_flags;
      next_cur.fire = fireNow;
      next_cur.fireDelayed = 1'b0;
      if (cur.delayPend) begin
         if (cur.delayCnt <= 3'h1) begin
            next_cur.fireDelayed = 1'b1;
            next_cur.delayPend   = 1'b0;
         end else begin
            next_cur.delayCnt = cur.delayCnt - 3'h1;
         end
      end
      if (fireNow[0]) begin
         if (cyc == 3'h0) begin
            next_cur.fireDelayed = 1'b1;
            next_cur.delayPend   = 1'b0;
         end else begin
            next_cur.delayPend = 1'b1;
            next_cur.delayCnt  = cyc;
         end
      end
      if (cur.unit_soft_reset_bits[0]) begin
         next_cur.delayPend = 1'b0;
      end
      next_cur.ppsWidth = {cur.last_unit_pulse_width_upper,
                           last_unit_config_second};
      next_cur.irq = |((next_cur.event_done_flags | next_cur.unit_error_flags)
                       & trigger_interrupt_enable);
      next_cur.rdValid = regRead;
      next_cur.rdata   = 16'h0000;
      if (regRead) begin
         unique case (regAddr)
            ADDR_ERROR:    next_cur.rdata = pad12(cur.unit_error_flags);
            ADDR_ACTIVE:   next_cur.rdata = pad12(cur.active);
            ADDR_DONE:     next_cur.rdata = pad12(cur.event_done_flags);
            ADDR_ARM:      next_cur.rdata = pad12(cur.unit_arm_bits);
            ADDR_SOFT_RST: next_cur.rdata = pad12(cur.unit_soft_reset_bits);
            ADDR_WIDTH_COMP:
               next_cur.rdata = {4'h0, cur.fineStep, cur.delaySel,
                                 cur.last_unit_pulse_width_upper};
            default:       next_cur.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
         cur.unit_arm_bits <= RST_UNITS;
         cur.event_done_flags <= RST_UNITS;
         cur.unit_error_flags <= RST_UNITS;
         cur.unit_soft_reset_bits <= RST_UNITS;
         cur.last_unit_pulse_width_upper <= RST_WIDTH_UPPER;
         cur.delaySel <= RST_DELAY_SEL;
         cur.fineStep <= RST_FINE_STEP;
         cur.active <= RST_UNITS;
         cur.fire <= RST_UNITS;
         cur.delayCnt <= RST_DELAY_CNT;
         cur.delayPend <= 1'b0;
         cur.fireDelayed <= 1'b0;
         cur.ppsWidth <= RST_PPS_WIDTH;
         cur.irq <= 1'b0;
         cur.rdata <= RST_RDATA;
         cur.rdValid <= 1'b0;
      end else begin
         cur <= next_cur;
      end
   end

   assign regRdata           = cur.rdata;
   assign regRdValid         = cur.rdValid;
   assign unitFire           = cur.fire;
   assign unit1FireDelayed   = cur.fireDelayed;
   assign unitSoftReset      = cur.unit_soft_reset_bits;
   assign unit_active_flags  = cur.active;
   assign lastUnitPulseWidth = cur.ppsWidth;
   assign trigIrq            = cur.irq;
endmodule

/* File: tb/pto_trigger_ctrl_monitor.sv */
// port assertions for the trigger output control block
`timescale 1ns/1ps
module pto_trigger_ctrl_monitor
   import pto_pkg::*;
(
   input wire logic               clk,
   input wire logic               rst_n,
   input wire logic [9:0]         regAddr,
   input wire logic               regWrite,
   input wire logic               regRead,
   input wire logic [15:0]        regWdata,
   input wire logic [15:0]        regRdata,
   input wire logic               regRdValid,
   input wire logic [UNITS-1:0]   trigger_interrupt_enable,
   input wire logic [UNITS-1:0]   targetReached,
   input wire logic [UNITS-1:0]   targetPast,
   input wire logic [15:0]        last_unit_config_second,
   input wire logic [UNITS-1:0]   unitFire,
   input wire logic [UNITS-1:0]   unitSoftReset,
   input wire logic [23:0]        lastUnitPulseWidth,
   input wire logic               trigIrq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   read_answer_a: assert property (
      regRead |=> regRdValid) else $error("read not answered");
   valid_cause_a: assert property (
      regRdValid |-> $past(regRead)) else $error("stray read valid");
   reserved_zero_a: assert property (
      regRdValid |-> regRdata[15:12] == 4'h0) else $error("high bits set");
   idle_zero_a: assert property (
      !regRdValid |-> regRdata == 16'h0000) else $error("idle data");
   fire_pulse_a: assert property (
      (unitFire & $past(unitFire)) == '0) else $error("long fire");
   fire_cause_a: assert property (
      (unitFire & ~$past(targetReached | targetPast)) == '0)
      else $error("fire without target");
   soft_pulse_a: assert property (
      regWrite && regAddr == ADDR_SOFT_RST |=>
      unitSoftReset == $past(regWdata[11:0])) else $error("soft reset");
   width_follow_a: assert property (
      $past(rst_n, 2) |-> lastUnitPulseWidth[15:0] ==
      $past(last_unit_config_second)) else $error("width low word");
   irq_gate_a: assert property (
      trigIrq |-> $past(trigger_interrupt_enable) != '0)
      else $error("irq ungated");
   cover property (unitFire[0]);
   cover property (trigIrq);
   cover property (unitSoftReset != '0);
endmodule
bind pto_trigger_ctrl pto_trigger_ctrl_monitor u_mon (.clk, .rst_n,
   .regAddr, .regWrite, .regRead, .regWdata, .regRdata, .regRdValid,
   .trigger_interrupt_enable, .targetReached, .targetPast,
   .last_unit_config_second, .unitFire, .unitSoftReset,
   .lastUnitPulseWidth, .trigIrq);

/* File: tb/pto_time_model.sv */
// precision clock stand-in comparing time with one target
`timescale 1ns/1ps
module pto_time_model
   import pto_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [15:0]      targetTime,
   output logic      [UNITS-1:0] targetReached,
   output logic      [UNITS-1:0] targetPast
);
   logic [15:0] sysTime;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) sysTime <= 16'h0000;
      else sysTime <= sysTime + 16'h0001;
   end
   assign targetReached = {UNITS{sysTime >= targetTime}};
   assign targetPast    = {UNITS{sysTime > targetTime}};
endmodule

/* File: tb/test_ptp_trigger_output_control.sv */
// register-level tests of the trigger output control block
`timescale 1ns/1ps
module test_ptp_trigger_output_control;
   import pto_pkg::*;
   logic clk = 0, rst_n = 0, regWrite = 0, regRead = 0, dly, irq;
   logic [9:0]         regAddr  = '0;
   logic [15:0]        regWdata = '0, tgt = '0, cfg2 = 16'h1234, rdat;
   logic [UNITS-1:0]   ie = '0, nfy = '1, now = '1, csc = '0;
   logic [UNITS-1:0]   reach, past, fire, srst, act;
   logic [4*UNITS-1:0] ups = '0;
   logic [23:0]        pw;
   logic               rdv;
   int                 n_mismatch = 0, n_compared = 0, k;
   always #2.5 clk = ~clk;
   pto_time_model u_time (.clk(clk), .rst_n(rst_n), .targetTime(tgt),
      .targetReached(reach), .targetPast(past));
   pto_trigger_ctrl u_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
      .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
      .regRdata(rdat), .regRdValid(rdv), .trigger_interrupt_enable(ie),
      .notify_option(nfy), .triggerNow(now), .cascadeMode(csc),
      .upstreamSel(ups), .targetReached(reach), .targetPast(past),
      .last_unit_config_second(cfg2), .unitFire(fire),
      .unit1FireDelayed(dly), .unitSoftReset(srst),
      .unit_active_flags(act), .lastUnitPulseWidth(pw), .trigIrq(irq));
   task automatic give_verdict();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [23:0] s, e);
      n_compared++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [9:0] a, input logic [15:0] e);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 chk("reg", rdat, e);
   endtask
   task automatic wf(input int i);
      for (k = 0; k < 40; k++) begin
         #1;
         if (fire[i] === 1'b1) break;
         @(posedge clk);
      end
      if (k == 40) begin
         n_mismatch++;
         give_verdict();
      end
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      for (int j = 0; j < 7; j++) rd(10'h200 + 10'(2 * j), 16'h0000);
      wr(ADDR_WIDTH_COMP, 16'hFFAB);
      rd(ADDR_WIDTH_COMP, 16'h0FAB);
      chk("width", pw, {8'hAB, cfg2});
      ie <= '1;
      for (int j = 0; j < UNITS; j++) begin
         wr(ADDR_ARM, 16'(1 << j));
         wf(j);
         rd(ADDR_ARM, 16'h0000);
         rd(ADDR_DONE, 16'(1 << j));
         chk("irq", irq, 1'b1);
         wr(ADDR_DONE, 16'h0000);
         rd(ADDR_DONE, 16'(1 << j));
         wr(ADDR_DONE, 16'(1 << j));
         rd(ADDR_DONE, 16'h0000);
         chk("irq", irq, 1'b0);
      end
      $display("fire test done");
      for (int j = 0; j < 2; j++) begin
         wr(ADDR_WIDTH_COMP, j ? 16'h0700 : 16'h0F00);
         wr(ADDR_ARM, 16'h0001);
         wf(0);
         for (k = 0; dly !== 1'b1 && k < 9; k++) begin
            @(posedge clk);
            #1;
         end
         chk("delay", 24'(k), j ? 24'h5 : 24'h1);
         wr(ADDR_DONE, 16'hFFFF);
      end
      ie <= '0;
      wr(ADDR_ARM, 16'h0004);
      wf(2);
      rd(ADDR_DONE, 16'h0004);
      chk("irq", irq, 1'b0);
      wr(ADDR_DONE, 16'h0004);
      now <= '0;
      ie <= '1;
      wr(ADDR_ARM, 16'h0010);
      rd(ADDR_ERROR, 16'h0010);
      chk("irq", irq, 1'b1);
      chk("act", act, 12'h000);
      wr(ADDR_ARM, 16'h0000);
      rd(ADDR_ERROR, 16'h0000);
      tgt <= 16'hFFFF;
      wr(ADDR_ARM, 16'h0020);
      rd(ADDR_ACTIVE, 16'h0020);
      wr(ADDR_SOFT_RST, 16'h0020);
      #1 chk("srst", srst, 12'h020);
      rd(ADDR_ARM, 16'h0000);
      rd(ADDR_SOFT_RST, 16'h0000);
      $display("error and soft reset tests done");
      tgt <= 16'h0000;
      now <= '1;
      csc <= 12'h002;
      wr(ADDR_ARM, 16'h0001);
      wf(0);
      wf(1);
      rd(ADDR_DONE, 16'h0003);
      $display("cascade test done");
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd(ADDR_DONE, 16'h0000);
      chk("act", act, 12'h000);
      $display("mid-run reset test done");
      give_verdict();
   end
endmodule
